// >>> verilog/sfrbw_top.sv
// serial command front end: array reads, buffer reads and buffer writes
`timescale 1ns/1ps
`default_nettype none
`include "sfrbw_params.svh"

module sfrbw_top #(
   parameter int PAGE_BITS = `SFRBW_PAGE_BITS,
   parameter int BYTE_BITS = `SFRBW_BYTE_BITS,
   parameter int BUF_DEPTH = `SFRBW_BUF_DEPTH
) (
   input wire logic ref_clk, // 200 mhz clock
   input wire logic nrst, // sync reset, active low
   input wire logic ce, // clock enable
   input wire logic cs_n, // chip select pin, active low
   input wire logic sck, // serial clock pin
   input wire logic si, // serial data in pin
   input wire logic page_256, // 1 = 256-byte pages
   input wire logic [7:0] array_data, // array byte at array_page/byte
   output logic so, // serial data out
   output logic so_oe, // serial out drive enable
   output logic array_rd, // main array read in progress
   output logic [PAGE_BITS-1:0] array_page, // array page number
   output logic [BYTE_BITS-1:0] array_byte // array byte in page
);

   logic [3:0] pin_q;
   logic cs_f;
   logic sck_f;
   logic si_f;
   logic sck_prev_ff;
   logic cs_prev_ff;
   logic sck_rise;
   logic sck_fall;
   logic cs_rise;
   logic active;

   sfrbw_sync #(
      .W(4),
      .RST(`SFRBW_PIN_RST)
   ) u_sync (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .ce(ce),
      .d({page_256, si, sck, cs_n}),
      .q(pin_q)
   );

   assign cs_f = pin_q[`SFRBW_PIN_CS];
   assign sck_f = pin_q[`SFRBW_PIN_SCK];
   assign si_f = pin_q[`SFRBW_PIN_SI];

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         sck_prev_ff <= 1'b0;
         cs_prev_ff <= 1'b1;
      end else if (ce) begin
         sck_prev_ff <= sck_f;
         cs_prev_ff <= cs_f;
      end
   end

   assign active = ~cs_f;
   assign sck_rise = active & sck_f & ~sck_prev_ff;
   assign sck_fall = active & ~sck_f & sck_prev_ff;
   assign cs_rise = cs_f & ~cs_prev_ff;

   sfrbw_pkg::sfrbw_state_t state_ff;
   sfrbw_pkg::sfrbw_src_t src_ff;
   logic [2:0] bit_cnt_ff;
   logic [2:0] byte_cnt_ff;
   logic [7:0] sh_in_ff;
   logic [15:0] addr_hi_ff;
   logic [7:0] out_sh_ff;
   logic [2:0] dummy_ff;
   logic is_wr_ff;
   logic buf_sel_ff;
   logic mode256_ff;
   logic [BYTE_BITS-1:0] buf_ptr_ff;
   logic so_ff;
   logic so_oe_ff;
   logic array_rd_ff;
   logic [PAGE_BITS-1:0] page_ff;
   logic [BYTE_BITS-1:0] byte_ff;
   logic [1:0] buf_we_ff;
   logic [BYTE_BITS-1:0] buf_waddr_ff;
   logic [7:0] buf_wdata_ff;
   logic [7:0] buf_rdata [2];

   logic [7:0] in_byte;
   logic [23:0] full_addr;
   logic [PAGE_BITS-1:0] start_page;
   logic [BYTE_BITS-1:0] start_byte;
   logic [BYTE_BITS-1:0] last_pos;
   logic [7:0] cur_byte;
   logic opc_ok;
   logic opc_wr;
   logic opc_buf2;
   logic [2:0] opc_dummy;
   sfrbw_pkg::sfrbw_src_t opc_src;

   assign in_byte = {sh_in_ff[6:0], si_f};
   assign full_addr = {addr_hi_ff, in_byte};

   // address split chosen by the latched page size
   always_comb begin
      if (mode256_ff) begin
         start_page = full_addr[22:8]; // RULE_03
         start_byte = {1'b0, full_addr[7:0]}; // RULE_14 RULE_19
         last_pos = `SFRBW_LAST_256;
      end else begin
         start_page = full_addr[23:9]; // RULE_02
         start_byte = full_addr[8:0]; // RULE_13 RULE_18
         last_pos = `SFRBW_LAST_264;
      end
   end

   // opcode decode
   always_comb begin
      opc_ok = 1'b1;
      opc_wr = 1'b0;
      opc_buf2 = 1'b0;
      opc_dummy = `SFRBW_DUMMY_NONE;
      opc_src = sfrbw_pkg::SRC_CONT;
      case (in_byte)
         `SFRBW_OPC_READ_LF: begin
            opc_src = sfrbw_pkg::SRC_CONT; // RULE_01
         end
         `SFRBW_OPC_READ_LP: begin
            opc_src = sfrbw_pkg::SRC_CONT; // RULE_04
         end
         `SFRBW_OPC_PAGE_RD: begin
            opc_src = sfrbw_pkg::SRC_PAGE;
            opc_dummy = `SFRBW_DUMMY_PAGE_RD; // RULE_10
         end
         `SFRBW_OPC_B1_RD_HI: begin
            opc_src = sfrbw_pkg::SRC_BUF; // RULE_12
            opc_dummy = `SFRBW_DUMMY_BUF_HI; // RULE_15
         end
         `SFRBW_OPC_B2_RD_HI: begin
            opc_src = sfrbw_pkg::SRC_BUF;
            opc_buf2 = 1'b1;
            opc_dummy = `SFRBW_DUMMY_BUF_HI; // RULE_15
         end
         `SFRBW_OPC_B1_RD_LO: begin
            opc_src = sfrbw_pkg::SRC_BUF; // RULE_12
         end
         `SFRBW_OPC_B2_RD_LO: begin
            opc_src = sfrbw_pkg::SRC_BUF;
            opc_buf2 = 1'b1;
         end
         `SFRBW_OPC_B1_WR: begin
            opc_wr = 1'b1; // RULE_17
         end
         `SFRBW_OPC_B2_WR: begin
            opc_wr = 1'b1;
            opc_buf2 = 1'b1; // RULE_17
         end
         default: begin
            opc_ok = 1'b0;
         end
      endcase
   end

   assign cur_byte = (src_ff == sfrbw_pkg::SRC_BUF) ? buf_rdata[buf_sel_ff] : array_data;

   // command sequencing
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         state_ff <= sfrbw_pkg::ST_OPC;
         bit_cnt_ff <= 3'h0;
         byte_cnt_ff <= 3'h0;
      end else if (ce) begin
         if (cs_f) begin
            state_ff <= sfrbw_pkg::ST_OPC; // RULE_07 RULE_21
            bit_cnt_ff <= 3'h0;
            byte_cnt_ff <= 3'h0;
         end else if (sck_fall && state_ff == sfrbw_pkg::ST_READ) begin
            bit_cnt_ff <= bit_cnt_ff + 3'h1; // RULE_22
         end else if (sck_rise && state_ff != sfrbw_pkg::ST_READ) begin
            bit_cnt_ff <= bit_cnt_ff + 3'h1;
            if (bit_cnt_ff == 3'h7) begin
               case (state_ff)
                  sfrbw_pkg::ST_OPC: begin
                     byte_cnt_ff <= 3'h0;
                     state_ff <= opc_ok ? sfrbw_pkg::ST_ADDR : sfrbw_pkg::ST_SKIP;
                  end
                  sfrbw_pkg::ST_ADDR: begin
                     byte_cnt_ff <= byte_cnt_ff + 3'h1;
                     if (byte_cnt_ff == `SFRBW_ADDR_BYTES - 3'h1) begin
                        byte_cnt_ff <= 3'h0;
                        if (is_wr_ff) begin
                           state_ff <= sfrbw_pkg::ST_WRITE;
                        end else if (dummy_ff == `SFRBW_DUMMY_NONE) begin
                           state_ff <= sfrbw_pkg::ST_READ; // RULE_01 RULE_04
                        end else begin
                           state_ff <= sfrbw_pkg::ST_DUMMY;
                        end
                     end
                  end
                  sfrbw_pkg::ST_DUMMY: begin
                     byte_cnt_ff <= byte_cnt_ff + 3'h1;
                     if (byte_cnt_ff == dummy_ff - 3'h1) begin
                        state_ff <= sfrbw_pkg::ST_READ; // RULE_10 RULE_15
                     end
                  end
                  default: begin
                     state_ff <= state_ff;
                  end
               endcase
            end
         end
      end
   end

   // serial input shifter, opcode attributes and address capture
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         sh_in_ff <= 8'h00;
         addr_hi_ff <= 16'h0000;
         dummy_ff <= 3'h0;
         is_wr_ff <= 1'b0;
         buf_sel_ff <= 1'b0;
         src_ff <= sfrbw_pkg::SRC_CONT;
         mode256_ff <= 1'b0;
      end else if (ce && sck_rise) begin
         sh_in_ff <= in_byte;
         if (bit_cnt_ff == 3'h7 && state_ff == sfrbw_pkg::ST_OPC) begin
            dummy_ff <= opc_dummy;
            is_wr_ff <= opc_wr;
            buf_sel_ff <= opc_buf2;
            src_ff <= opc_src;
            mode256_ff <= pin_q[`SFRBW_PIN_P256]; // RULE_23
         end
         if (bit_cnt_ff == 3'h7 && state_ff == sfrbw_pkg::ST_ADDR) begin
            addr_hi_ff <= full_addr[15:0];
         end
      end
   end

   logic addr_done;
   logic load_byte;
   assign addr_done = sck_rise && bit_cnt_ff == 3'h7 && state_ff == sfrbw_pkg::ST_ADDR
                      && byte_cnt_ff == `SFRBW_ADDR_BYTES - 3'h1;
   assign load_byte = sck_fall && state_ff == sfrbw_pkg::ST_READ && bit_cnt_ff == 3'h0;

   // main array pointer
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         page_ff <= '0;
         byte_ff <= '0;
      end else if (ce) begin
         if (addr_done && !is_wr_ff && src_ff != sfrbw_pkg::SRC_BUF) begin
            page_ff <= start_page; // RULE_02 RULE_03
            byte_ff <= start_byte;
         end else if (load_byte && src_ff != sfrbw_pkg::SRC_BUF) begin
            if (byte_ff == last_pos) begin
               byte_ff <= '0;
               if (src_ff == sfrbw_pkg::SRC_CONT) begin
                  page_ff <= page_ff + 1'b1; // RULE_05 RULE_06
               end
            end else begin
               byte_ff <= byte_ff + 1'b1; // RULE_11
            end
         end
      end
   end

   // buffer pointer for reads and writes
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         buf_ptr_ff <= '0;
      end else if (ce) begin
         if (addr_done && (is_wr_ff || src_ff == sfrbw_pkg::SRC_BUF)) begin
            buf_ptr_ff <= start_byte; // RULE_13 RULE_14 RULE_18 RULE_19
         end else if ((load_byte && src_ff == sfrbw_pkg::SRC_BUF)
                      || (sck_rise && bit_cnt_ff == 3'h7 && state_ff == sfrbw_pkg::ST_WRITE)) begin
            buf_ptr_ff <= (buf_ptr_ff == last_pos) ? '0 : buf_ptr_ff + 1'b1; // RULE_16 RULE_20
         end
      end
   end

   // buffer write strobe, only ever raised by a write command
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         buf_we_ff <= 2'b00;
         buf_waddr_ff <= '0;
         buf_wdata_ff <= 8'h00;
      end else if (ce) begin
         buf_we_ff <= 2'b00;
         if (sck_rise && bit_cnt_ff == 3'h7 && state_ff == sfrbw_pkg::ST_WRITE) begin
            buf_we_ff[buf_sel_ff] <= 1'b1; // RULE_08 RULE_21
            buf_waddr_ff <= buf_ptr_ff; // RULE_20
            buf_wdata_ff <= in_byte;
         end
      end
   end

   genvar b;
   generate
      for (b = 0; b < 2; b++) begin : g_buf
         sfrbw_buf #(
            .DEPTH(BUF_DEPTH),
            .AW(BYTE_BITS),
            .DW(8)
         ) u_buf (
            .ref_clk(ref_clk),
            .nrst(nrst),
            .ce(ce),
            .we(buf_we_ff[b]),
            .waddr(buf_waddr_ff),
            .wdata(buf_wdata_ff),
            .raddr(buf_ptr_ff),
            .rdata(buf_rdata[b])
         );
      end
   endgenerate

   // serial output shifter
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         out_sh_ff <= 8'h00;
         so_ff <= 1'b0;
      end else if (ce && sck_fall && state_ff == sfrbw_pkg::ST_READ) begin
         if (bit_cnt_ff == 3'h0) begin
            out_sh_ff <= cur_byte;
            so_ff <= cur_byte[7]; // RULE_22
         end else begin
            out_sh_ff <= {out_sh_ff[6:0], 1'b0};
            so_ff <= out_sh_ff[6]; // RULE_22
         end
      end
   end

   // output enable and array read flag
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         so_oe_ff <= 1'b0;
         array_rd_ff <= 1'b0;
      end else if (ce) begin
         if (cs_f || cs_rise) begin
            so_oe_ff <= 1'b0; // RULE_07
            array_rd_ff <= 1'b0;
         end else if (state_ff == sfrbw_pkg::ST_READ) begin
            so_oe_ff <= 1'b1;
            array_rd_ff <= src_ff != sfrbw_pkg::SRC_BUF; // RULE_08
         end
      end
   end

   assign so = so_ff;
   assign so_oe = so_oe_ff;
   assign array_rd = array_rd_ff;
   assign array_page = page_ff;
   assign array_byte = byte_ff;

endmodule : sfrbw_top

`default_nettype wire

// >>> include/sfrbw_params.svh
// constants for the serial flash read and buffer write front end
// How it works
// RULE_01 - opcode 03h, three address bytes, no dummies
// RULE_02 - 264 mode: 15 page bits, 9 byte bits
// RULE_03 - 256 mode: 15 page bits, 8 byte bits
// RULE_04 - opcode 01h behaves like 03h read
// RULE_05 - continuous read crosses into next page seamlessly
// RULE_06 - end of array wraps to page zero
// RULE_07 - chip select rise ends read, output released
// RULE_08 - main array reads never touch buffers
// RULE_09 - host holds chip select low whole command
// RULE_10 - opcode D2h, address, four dummy bytes
// RULE_11 - page read wraps within same page
// RULE_12 - D4h/D1h first buffer, D6h/D3h second
// RULE_13 - 264 buffer read: 15 ignored, 9 position
// RULE_14 - 256 buffer read: 16 ignored, 8 position
// RULE_15 - D4h/D6h need one dummy byte
// RULE_16 - buffer read wraps to first byte
// RULE_17 - 84h/87h write first/second buffer
// RULE_18 - 264 write: 9 low bits start position
// RULE_19 - 256 write: 16 ignored, 8 position
// RULE_20 - write stores increasing positions, wraps around
// RULE_21 - write continues until chip select rises
// RULE_22 - each later clock shifts next data bit
// RULE_23 - page size input selects address split
`ifndef SFRBW_PARAMS_SVH
`define SFRBW_PARAMS_SVH

`define SFRBW_OPC_READ_LF 8'h03
`define SFRBW_OPC_READ_LP 8'h01
`define SFRBW_OPC_PAGE_RD 8'hd2
`define SFRBW_OPC_B1_RD_HI 8'hd4
`define SFRBW_OPC_B1_RD_LO 8'hd1
`define SFRBW_OPC_B2_RD_HI 8'hd6
`define SFRBW_OPC_B2_RD_LO 8'hd3
`define SFRBW_OPC_B1_WR 8'h84
`define SFRBW_OPC_B2_WR 8'h87

`define SFRBW_DUMMY_NONE 3'h0
`define SFRBW_DUMMY_PAGE_RD 3'h4
`define SFRBW_DUMMY_BUF_HI 3'h1

`define SFRBW_ADDR_BYTES 3'h3
`define SFRBW_LAST_264 9'h107
`define SFRBW_LAST_256 9'h0ff
`define SFRBW_BUF_DEPTH 264
`define SFRBW_PAGE_BITS 15
`define SFRBW_BYTE_BITS 9

`define SFRBW_PIN_CS 0
`define SFRBW_PIN_SCK 1
`define SFRBW_PIN_SI 2
`define SFRBW_PIN_P256 3
`define SFRBW_PIN_RST 4'h1

`endif

// >>> include/sfrbw_pkg.sv
// types for the serial flash read and buffer write front end
package sfrbw_pkg;

   typedef enum logic [2:0] {
      ST_OPC = 3'b000,
      ST_ADDR = 3'b001,
      ST_DUMMY = 3'b010,
      ST_READ = 3'b011,
      ST_WRITE = 3'b100,
      ST_SKIP = 3'b101
   } sfrbw_state_t;

   typedef enum logic [1:0] {
      SRC_CONT = 2'b00,
      SRC_PAGE = 2'b01,
      SRC_BUF = 2'b10
   } sfrbw_src_t;

endpackage : sfrbw_pkg

// >>> verilog/sfrbw_sync.sv
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none

module sfrbw_sync #(
   parameter int W = 4,
   parameter logic [W-1:0] RST = '0
) (
   input wire logic ref_clk, // clock
   input wire logic nrst, // sync reset
   input wire logic ce, // clock enable
   input wire logic [W-1:0] d, // async inputs
   output logic [W-1:0] q // filtered level
);

   logic [W-1:0] s1_ff;
   logic [W-1:0] s2_ff;
   logic [W-1:0] s3_ff;

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         s1_ff <= RST;
         s2_ff <= RST;
         s3_ff <= RST;
      end else if (ce) begin
         s1_ff <= d;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
      end
   end

   wire [W-1:0] nxt_q;

   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         // a change counts once stages two and three agree
         assign nxt_q[i] = (s2_ff[i] == s3_ff[i]) ? s3_ff[i] : q[i];
      end
   endgenerate

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         q <= RST;
      end else if (ce) begin
         q <= nxt_q;
      end
   end

endmodule : sfrbw_sync

`default_nettype wire

// >>> verilog/sfrbw_buf.sv
// one sram data buffer, one write and one registered read port
`timescale 1ns/1ps
`default_nettype none

module sfrbw_buf #(
   parameter int DEPTH = 264,
   parameter int AW = 9,
   parameter int DW = 8
) (
   input wire logic ref_clk, // clock
   input wire logic nrst, // sync reset
   input wire logic ce, // clock enable
   input wire logic we, // write strobe
   input wire logic [AW-1:0] waddr, // write position
   input wire logic [DW-1:0] wdata, // write byte
   input wire logic [AW-1:0] raddr, // read position
   output logic [DW-1:0] rdata // read byte, one cycle late
);

   logic [DW-1:0] mem [DEPTH];

   always_ff @(posedge ref_clk) begin
      if (ce && we) begin
         mem[waddr] <= wdata;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         rdata <= '0;
      end else if (ce) begin
         rdata <= mem[raddr];
      end
   end

endmodule : sfrbw_buf

`default_nettype wire

// >>> tb/sfrbw_top_sva.sv
// assertion checker for the serial flash command front end
`timescale 1ns/1ps
`default_nettype none

module sfrbw_top_sva #(
   parameter int PAGE_BITS = 15,
   parameter int BYTE_BITS = 9
) (
   input wire logic ref_clk, // clock
   input wire logic nrst, // sync reset
   input wire logic ce, // clock enable
   input wire logic cs_n, // chip select
   input wire logic sck, // serial clock
   input wire logic si, // serial in
   input wire logic page_256, // page size
   input wire logic [7:0] array_data, // array byte
   input wire logic so, // serial out
   input wire logic so_oe, // out enable
   input wire logic array_rd, // array read
   input wire logic [PAGE_BITS-1:0] array_page, // page pointer
   input wire logic [BYTE_BITS-1:0] array_byte // byte pointer
);
   logic [BYTE_BITS-1:0] last_pos;
   assign last_pos = page_256 ? BYTE_BITS'(255) : BYTE_BITS'(263);

   default clocking @(posedge ref_clk); endclocking
   default disable iff (!nrst);

   sequence s_deselected;
      cs_n [*8];
   endsequence
   sequence s_byte_moved;
      array_rd && $past(array_rd) && $changed(array_byte);
   endsequence
   sequence s_page_moved;
      array_rd && $past(array_rd) && $changed(array_page);
   endsequence

   a_release_out: assert property (s_deselected |-> !so_oe)
      else $error("serial out still driven after deselect");
   a_read_ends: assert property (s_deselected |-> !array_rd)
      else $error("array read still active after deselect");
   a_ptr_frozen: assert property (s_deselected |=> $stable(array_byte) && $stable(array_page))
      else $error("pointers move while deselected");
   a_byte_step: assert property (s_byte_moved |->
      array_byte == (($past(array_byte) == last_pos) ? '0 : $past(array_byte) + 1'b1))
      else $error("byte pointer step wrong");
   a_page_step: assert property (s_page_moved |-> array_byte == '0 &&
      $past(array_byte) == last_pos && array_page == $past(array_page) + 1'b1)
      else $error("page pointer step wrong");
   a_byte_range: assert property (array_rd |-> array_byte <= last_pos)
      else $error("byte pointer beyond page end");
   a_so_after_fall: assert property (so_oe && $past(so_oe) && $changed(so) |-> !sck)
      else $error("serial out changed while clock high");
   a_oe_in_frame: assert property ($rose(so_oe) |-> !cs_n)
      else $error("serial out enabled outside a frame");
   a_rd_drives_out: assert property ($rose(array_rd) |-> ##[0:2] so_oe)
      else $error("array read without serial out drive");
endmodule : sfrbw_top_sva

bind sfrbw_top sfrbw_top_sva #(.PAGE_BITS(PAGE_BITS), .BYTE_BITS(BYTE_BITS)) i_sfrbw_top_sva (
   .ref_clk(ref_clk), .nrst(nrst), .ce(ce), .cs_n(cs_n), .sck(sck), .si(si), .page_256(page_256),
   .array_data(array_data), .so(so), .so_oe(so_oe), .array_rd(array_rd), .array_page(array_page),
   .array_byte(array_byte));

`default_nettype wire

// >>> tb/sfrbw_host.sv
// spi host model, mode 0, driving select, clock and data
`timescale 1ns/1ps
`default_nettype none

module sfrbw_host (
   output logic cs_n, // chip select
   output logic sck, // serial clock
   output logic si, // data to device
   input wire logic so // data from device
);
   initial begin
      cs_n = 1'b1;
      sck = 1'b0;
      si = 1'b0;
   end

   // data line carries noise while deselected
   // toggles just after a clock edge, like every other input change
   initial begin
      #3.5;
      forever #40 if (cs_n) si = ~si;
   end

   task start();
      cs_n = 1'b0;
      #40;
   endtask : start

   task xbyte(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         si = tx[i];
         #40 sck = 1'b1;
         rx[i] = so;
         #40 sck = 1'b0;
      end
   endtask : xbyte

   task stop();
      #40 cs_n = 1'b1;
   endtask : stop
endmodule : sfrbw_host

`default_nettype wire

// >>> tb/sfrbw_top_tb_top.sv
// self-checking bench for the serial flash command front end
`timescale 1ns/1ps
`default_nettype none

module sfrbw_top_tb_top;
   logic ref_clk = 1'b0;
   logic nrst = 1'b0;
   logic page_256 = 1'b0;
   logic cs_n, sck, si, so, so_oe, array_rd, so_pin;
   logic [7:0] array_data;
   logic [14:0] array_page;
   logic [8:0] array_byte;
   logic [7:0] mem [2][264];
   logic [7:0] rx;
   int n_mismatch = 0;
   int checked = 0;

   always #2.5 ref_clk = ~ref_clk;

   function automatic logic [7:0] arr(logic [14:0] p, logic [8:0] b);
      return p[7:0] ^ b[7:0] ^ {b[8], p[14:8]};
   endfunction : arr

   assign array_data = arr(array_page, array_byte);
   assign so_pin = so_oe ? so : ~so;

   sfrbw_top i_sfrbw_top (.ref_clk(ref_clk), .nrst(nrst), .ce(1'b1), .cs_n(cs_n), .sck(sck), .si(si),
      .page_256(page_256), .array_data(array_data), .so(so), .so_oe(so_oe), .array_rd(array_rd),
      .array_page(array_page), .array_byte(array_byte));
   sfrbw_host i_sfrbw_host (.cs_n(cs_n), .sck(sck), .si(si), .so(so_pin));

   task chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask : chk

   task results();
      $display("checks %0d, mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : results

   task cmd(input logic [7:0] opc, input logic p256, input logic [23:0] a, input int dum);
      @(posedge ref_clk);
      #1 page_256 = p256;
      repeat (2) @(posedge ref_clk);
      #1 i_sfrbw_host.start();
      i_sfrbw_host.xbyte(opc, rx);
      for (int i = 2; i >= 0; i--) i_sfrbw_host.xbyte(a[8*i +: 8], rx);
      repeat (dum) i_sfrbw_host.xbyte(8'h00, rx);
   endtask : cmd

   task fin();
      i_sfrbw_host.stop();
      repeat (10) @(posedge ref_clk);
      #1;
      chk("so_oe", {7'h0, so_oe}, 8'h00);
      chk("array_rd", {7'h0, array_rd}, 8'h00);
   endtask : fin

   task rd_arr(input logic [7:0] opc, input logic p256, input logic [14:0] p, input logic [8:0] b,
      input int n);
      logic [8:0] last;
      last = p256 ? 9'h0ff : 9'h107;
      cmd(opc, p256, p256 ? {1'b0, p, b[7:0]} : {p, b}, (opc == 8'hd2) ? 4 : 0);
      for (int k = 0; k < n; k++) begin
         i_sfrbw_host.xbyte(8'h00, rx);
         chk("array byte", rx, arr(p, b));
         if (b == last) begin
            b = 9'h000;
            if (opc != 8'hd2) p = p + 15'h0001;
         end else b = b + 9'h001;
      end
      chk("array_rd", {7'h0, array_rd}, 8'h01);
      chk("so_oe", {7'h0, so_oe}, 8'h01);
      fin();
   endtask : rd_arr

   task wr_buf(input logic sel, input logic p256, input logic [8:0] pos, input int n);
      logic [7:0] d;
      cmd(sel ? 8'h87 : 8'h84, p256, p256 ? {16'hc3a5, pos[7:0]} : {15'h4b2d, pos}, 0);
      for (int k = 0; k < n; k++) begin
         d = {pos[3:0], 3'h5, sel} ^ 8'(k * 37);
         i_sfrbw_host.xbyte(d, rx);
         mem[sel][pos] = d;
         pos = (pos == (p256 ? 9'h0ff : 9'h107)) ? 9'h000 : pos + 9'h001;
      end
      fin();
   endtask : wr_buf

   task rd_buf(input logic [7:0] opc, input logic sel, input logic p256, input logic [8:0] pos, input int n);
      cmd(opc, p256, p256 ? {16'h5a3c, pos[7:0]} : {15'h2d4b, pos}, (opc == 8'hd4 || opc == 8'hd6) ? 1 : 0);
      for (int k = 0; k < n; k++) begin
         i_sfrbw_host.xbyte(8'h00, rx);
         chk("buffer byte", rx, mem[sel][pos]);
         pos = (pos == (p256 ? 9'h0ff : 9'h107)) ? 9'h000 : pos + 9'h001;
      end
      chk("array_rd", {7'h0, array_rd}, 8'h00);
      fin();
   endtask : rd_buf

   // an opcode outside the decoded set never drives the output
   task sc_bad();
      cmd(8'h0b, 1'b0, 24'h000000, 1);
      i_sfrbw_host.xbyte(8'h00, rx);
      chk("so_oe", {7'h0, so_oe}, 8'h00);
      fin();
   endtask : sc_bad

   task sc_buf_264();
      wr_buf(1'b0, 1'b0, 9'h107, 3);
      wr_buf(1'b1, 1'b0, 9'h106, 2);
      rd_buf(8'hd4, 1'b0, 1'b0, 9'h107, 3);
      rd_buf(8'hd3, 1'b1, 1'b0, 9'h106, 2);
   endtask : sc_buf_264

   task sc_buf_256();
      wr_buf(1'b1, 1'b1, 9'h0ff, 2);
      rd_buf(8'hd6, 1'b1, 1'b1, 9'h0ff, 2);
      rd_buf(8'hd1, 1'b0, 1'b1, 9'h000, 2);
   endtask : sc_buf_256

   task sc_cont();
      rd_arr(8'h03, 1'b0, 15'h0005, 9'h106, 3);
      rd_arr(8'h01, 1'b1, 15'h7fff, 9'h0fe, 3);
      rd_arr(8'h01, 1'b0, 15'h7fff, 9'h107, 2);
   endtask : sc_cont

   task sc_page();
      rd_arr(8'hd2, 1'b0, 15'h1234, 9'h106, 3);
      rd_arr(8'hd2, 1'b1, 15'h0042, 9'h0ff, 2);
   endtask : sc_page

   // buffers read back after the array reads
   task sc_keep();
      rd_buf(8'hd1, 1'b0, 1'b0, 9'h107, 3);
      rd_buf(8'hd6, 1'b1, 1'b1, 9'h0ff, 2);
   endtask : sc_keep

   initial begin
      repeat (3) @(posedge ref_clk);
      #1 nrst = 1'b1;
      repeat (6) @(posedge ref_clk);
      sc_buf_264();
      sc_buf_256();
      sc_cont();
      sc_page();
      sc_keep();
      sc_bad();
      results();
   end

   initial begin
      #200000;
      n_mismatch++;
      results();
   end
endmodule : sfrbw_top_tb_top

`default_nettype wire
